// ===== src/adc_port_pkg.sv
// Shared constants and types for the converter host port
package adc_port_pkg;
  localparam int unsigned RES_W          = 10;
  localparam logic [9:0]  CODE_FULL      = 10'h3FF;
  localparam logic [9:0]  CODE_ZERO      = 10'h000;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned CONV_TIME_NS   = 6000;
  localparam int unsigned CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W     = 8;
  localparam int unsigned SAR_STEPS      = RES_W;
  localparam int unsigned STEP_CYCLES    = CONV_CYCLES / SAR_STEPS;
  localparam int unsigned EXT_SW_NS      = 2000;
  localparam int unsigned EXT_SW_CYCLES  = EXT_SW_NS / CLK_PERIOD_NS;
  localparam int unsigned EXT_CNT_W      = 7;
  localparam int unsigned INT_DIV        = 5;
  localparam int unsigned DIV_W          = 3;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } host_strobe_t;

  typedef struct packed {
    logic [9:0] vin;
    logic [9:0] ref_hi;
    logic [9:0] ref_lo;
  } analog_t;
endpackage : adc_port_pkg

// ===== src/sar_engine.sv
// Successive approximation engine with reference clamping
`timescale 1ns/1ps
`default_nettype none
module sar_engine
  import adc_port_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Control
  input  wire logic             start,
  input  wire logic             step_en,
  input  wire logic [RES_W-1:0] held_in,
  input  wire logic [RES_W-1:0] ref_hi,
  input  wire logic [RES_W-1:0] ref_lo,
  // Result
  output logic                  done,
  output logic      [RES_W-1:0] code
);
  logic [RES_W-1:0] trial_q, mask_q;
  logic             busy_q;
  logic [RES_W-1:0] span;
  logic [RES_W-1:0] rel;
  logic [2*RES_W-1:0] scaled;
  logic [RES_W-1:0] target;

  assign span   = ref_hi - ref_lo;
  assign rel    = held_in - ref_lo;
  assign scaled = (span == CODE_ZERO) ? '0 : (rel * CODE_FULL) / span;
  assign target = (held_in >= ref_hi) ? CODE_FULL :
                  (held_in <= ref_lo) ? CODE_ZERO : scaled[RES_W-1:0];

  always_ff @(posedge ref_clk) begin
    done <= 1'b0;
    if (srst) begin
      busy_q  <= 1'b0;
      trial_q <= '0;
      mask_q  <= '0;
      code    <= '0;
    end else if (start) begin
      busy_q  <= 1'b1;
      trial_q <= 10'h200;
      mask_q  <= 10'h200;
    end else if (busy_q && step_en) begin
      if ((trial_q > target) && mask_q != '0) trial_q <= (trial_q & ~mask_q) | (mask_q >> 1);
      else trial_q <= trial_q | (mask_q >> 1);
      mask_q <= mask_q >> 1;
      if (mask_q == 10'h001) begin
        busy_q <= 1'b0;
        done   <= 1'b1;
        code   <= (trial_q > target) ? (trial_q & ~mask_q) : trial_q;
      end
    end
  end
endmodule : sar_engine
`default_nettype wire

// ===== src/sar_adc_parallel_host_port.sv
// Host port of a 10-bit converter: start, hold, latch, done flag, 3-state read
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_host_port
  import adc_port_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Host strobes
  input  wire host_strobe_t     strobe,
  // Analog side
  input  wire analog_t          analog_input,
  input  wire logic             external_clock_in,
  // Result bus
  output logic      [RES_W-1:0] result_bus_o,
  output logic      [RES_W-1:0] result_bus_oe_n,
  output logic                  done_n,
  output logic                  sampling
);
  logic             wr_q, rd_q, ext_q;
  logic             conv_q;
  logic [RES_W-1:0] hold_q;
  logic [RES_W-1:0] latch_q;
  logic             done_n_q;
  logic             use_ext_q;
  logic [EXT_CNT_W-1:0] idle_cnt_q;
  logic [DIV_W-1:0] div_q;
  logic             eng_done;
  logic [RES_W-1:0] eng_code;

  wire start_edge = ~strobe.cs_n & strobe.wr_n & ~wr_q;
  wire read_fall  = ~strobe.cs_n & ~strobe.rd_n & rd_q;
  wire read_on    = ~strobe.cs_n & ~strobe.rd_n;
  wire ext_rise   = external_clock_in & ~ext_q;
  wire int_tick   = (div_q == DIV_W'(INT_DIV - 1));
  wire step_en    = use_ext_q ? ext_rise : int_tick;
  wire start      = start_edge & ~conv_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      ext_q <= 1'b1;
    end else begin
      wr_q <= strobe.wr_n;
      rd_q <= strobe.rd_n;
      ext_q <= external_clock_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q      <= '0;
      use_ext_q  <= 1'b0;
      idle_cnt_q <= '0;
    end else begin
      div_q <= int_tick ? '0 : div_q + 1'b1;
      if (external_clock_in) begin
        if (idle_cnt_q == EXT_CNT_W'(EXT_SW_CYCLES)) use_ext_q <= 1'b0;
        else idle_cnt_q <= idle_cnt_q + 1'b1;
      end else begin
        idle_cnt_q <= '0;
        if (ext_rise | ~ext_q) use_ext_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      conv_q <= 1'b0;
      hold_q <= '0;
    end else begin
      if (start) conv_q <= 1'b1;
      else if (eng_done) conv_q <= 1'b0;
      if (!conv_q && !start) hold_q <= analog_input.vin;
    end
  end

  sar_engine u_sar (
    .ref_clk (ref_clk),
    .srst    (srst),
    .start   (start),
    .step_en (step_en),
    .held_in (hold_q),
    .ref_hi  (analog_input.ref_hi),
    .ref_lo  (analog_input.ref_lo),
    .done    (eng_done),
    .code    (eng_code)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_q  <= '0;
      done_n_q <= 1'b1;
    end else begin
      if (eng_done) latch_q <= eng_code;
      // Flag high on start, or on read unless eng_done lands in the same cycle
      if (start) done_n_q <= 1'b1;
      else if (eng_done) done_n_q <= 1'b0;
      else if (read_fall) done_n_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) result_bus_o <= '0;
    else result_bus_o <= latch_q;
  end
  assign result_bus_oe_n = read_on ? '0 : '1;
  assign done_n   = done_n_q;
  assign sampling = ~conv_q;

  a_flag_during_conv: assert property (@(posedge ref_clk) disable iff (srst)
    conv_q |-> done_n) else $error("flag low in conversion");
  a_start_sets_conv: assert property (@(posedge ref_clk) disable iff (srst)
    start |=> conv_q && !sampling) else $error("no hold after start");
  a_cs_gates_start: assert property (@(posedge ref_clk) disable iff (srst)
    (strobe.cs_n && !conv_q) |=> !conv_q) else $error("start without select");
  a_latch_then_flag: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(done_n) |-> latch_q == $past(eng_code)) else $error("flag before latch");
  a_latch_stable: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(eng_done) |-> $stable(latch_q)) else $error("latch changed");
  a_bus_float: assert property (@(posedge ref_clk) disable iff (srst)
    (strobe.cs_n || strobe.rd_n) |-> result_bus_oe_n == '1) else $error("bus driven");
  a_bus_drive: assert property (@(posedge ref_clk) disable iff (srst)
    read_on |=> result_bus_o == $past(latch_q) || !read_on) else $error("bus data wrong");
  a_read_clears: assert property (@(posedge ref_clk) disable iff (srst)
    (read_fall && !eng_done && !start) |=> done_n) else $error("flag not cleared");
  a_conv_bounded: assert property (@(posedge ref_clk) disable iff (srst)
    (start && !use_ext_q) |-> ##[1:60] !conv_q) else $error("conversion too long");
  c_conversion: cover property (@(posedge ref_clk) disable iff (srst) $fell(done_n));
  c_read: cover property (@(posedge ref_clk) disable iff (srst) !done_n ##1 read_fall);
  c_ext_clk: cover property (@(posedge ref_clk) disable iff (srst) use_ext_q && eng_done);
endmodule : sar_adc_parallel_host_port
`default_nettype wire

// ===== dv/host_bus_model.sv
// Host bus model: resolves the 3-state result bus as the processor sees it
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import adc_port_pkg::*;
(
  // Design side
  input  wire logic             ref_clk,
  input  wire logic [RES_W-1:0] result_bus_o,
  input  wire logic [RES_W-1:0] result_bus_oe_n,
  // Host side
  output logic      [RES_W-1:0] bus_level
);
  logic [RES_W-1:0] last_q = '0;
  always_ff @(posedge ref_clk) begin
    last_q <= bus_level;
  end
  // Line i carries bit i; released lines keep toggling
  assign bus_level = (result_bus_o & ~result_bus_oe_n) | (~last_q & result_bus_oe_n);
endmodule : host_bus_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the converter host port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_port_pkg::*;
  logic             ref_clk = 1'b0;
  logic             srst = 1'b1;
  logic             external_clock_in = 1'b1;
  host_strobe_t     strobe = 3'b111;
  analog_t          analog_input = '0;
  logic [RES_W-1:0] result_bus_o, result_bus_oe_n, bus_level;
  logic             done_n, sampling;
  logic             oe_seen = 1'b0;
  logic             ext_run = 1'b0;
  logic [3:0]       cyc = 4'h0;
  logic [RES_W-1:0] expq[$];
  logic [31:0]      seed = 32'd87681;
  int               n_mismatch = 0;
  int               checks_done = 0;
  sar_adc_parallel_host_port dut (.ref_clk(ref_clk), .srst(srst), .strobe(strobe), .analog_input(analog_input),
    .external_clock_in(external_clock_in), .result_bus_o(result_bus_o), .result_bus_oe_n(result_bus_oe_n),
    .done_n(done_n), .sampling(sampling));
  host_bus_model host (.ref_clk(ref_clk), .result_bus_o(result_bus_o), .result_bus_oe_n(result_bus_oe_n),
    .bus_level(bus_level));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // External clock of sixteen cycles while enabled, else held high
  always @(negedge ref_clk) begin
    cyc <= cyc + 4'h1;
    external_clock_in <= ext_run ? cyc[3] : 1'b1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Mid-scale values are exact only with full-span references
  function automatic logic [RES_W-1:0] code_of(input analog_t a);
    if (a.vin >= a.ref_hi) return CODE_FULL;
    if (a.vin <= a.ref_lo) return CODE_ZERO;
    return a.vin;
  endfunction : code_of
  task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic drive(input logic [2:0] s);
    @(negedge ref_clk);
    strobe = s;
    #1;
  endtask : drive
  task automatic convert(input logic cs, input analog_t a);
    int i;
    drive({cs, 2'b10});
    analog_input = a;
    drive({cs, 2'b11});
    drive(3'b111);
    drive(3'b111);
    // Input moves after the start edge and must not be seen
    analog_input.vin = ~a.vin;
    check({8'h00, sampling, done_n}, {8'h00, cs, 1'b1});
    for (i = 0; i < 200 && done_n !== 1'b0; i++) drive(3'b111);
    check({8'h00, sampling, done_n}, {9'h001, cs});
    if (!cs) check({9'h000, i > 40}, 10'h001);
    if (!cs) check({9'h000, i > 100}, {9'h000, ext_run});
  endtask : convert
  task automatic read(input logic [RES_W-1:0] exp);
    drive(3'b101);
    check(result_bus_oe_n, 10'h3FF);
    check({9'h000, done_n}, 10'h000);
    drive(3'b111);
    expq.push_back(exp);
    drive(3'b001);
    drive(3'b001);
    check({9'h000, done_n}, 10'h001);
    drive(3'b111);
    check(result_bus_oe_n, 10'h3FF);
  endtask : read
  // Monitor: each new read window is compared with the oldest note
  always @(posedge ref_clk) begin
    if (result_bus_oe_n === '0 && !oe_seen) check(bus_level, expq.pop_front());
    oe_seen = (result_bus_oe_n === '0);
  end
  initial begin
    analog_t a;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    #1;
    check({7'h00, done_n, sampling, &result_bus_oe_n}, 10'h007);
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      a = '{seed[9:0], CODE_FULL, CODE_ZERO};
      if (k == 0) a = '{10'h200, 10'h100, 10'h050};
      if (k == 1) a = '{10'h040, 10'h300, 10'h080};
      if (k == 2) a = '{10'h3FF, 10'h3FF, 10'h000};
      if (k == 3) a = '{10'h050, 10'h200, 10'h050};
      if (k == 8) begin
        ext_run = 1'b1;
        repeat (16) @(negedge ref_clk);
      end
      convert(k == 7, a);
      // An unread result is replaced by the next one
      if (k != 4 && k != 7) read(code_of(a));
    end
    complete_run();
  end
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
